// ---- inc/adc_ctl_pkg.sv ----
// Package: register map, field layout and constants of the converter control block
package adc_ctl_pkg;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] off_conv_control_reg0 = 8'h00;
	localparam logic [7:0] off_conv_control_reg1 = 8'h04;
	localparam logic [7:0] off_dual_ch1_select_reg = 8'h08;
	localparam logic [7:0] off_dual_ch2_select_reg = 8'h0c;
	localparam logic [7:0] off_pin_function_select = 8'h10;
	localparam logic [7:0] off_pin_pull_high = 8'h14;
	localparam logic [7:0] off_pin_direction = 8'h18;
	localparam logic [7:0] off_status = 8'h1c;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	// conv_control_reg0
	localparam int pos_ext_channel_select = 0;
	localparam int pos_start = 4;
	localparam int pos_converter_power_enable = 5;
	localparam int pos_mode = 6;
	// conv_control_reg1
	localparam int pos_conv_clock_divider_select = 0;
	localparam int pos_conv_source_select = 4;
	// dual channel select registers
	localparam int pos_dual_chan_signal_select = 0;
	localparam int pos_dual_chan_source_bit = 4;
	// status register
	localparam int pos_busy = 0;
	localparam int pos_phase_sample = 1;
	localparam int pos_active_channel = 2;
	// ----------------------------------------
	// Widths, counts and reset values
	// ----------------------------------------
	localparam int num_ext = 11;
	localparam int sample_periods = 4;
	localparam int convert_periods = 12;
	localparam int total_periods = sample_periods + convert_periods;
	localparam logic [31:0] reset_value = 32'h0000_0000;
	// ----------------------------------------
	// Codes
	// ----------------------------------------
	localparam logic [2:0] src_bandgap = 3'h1;
	localparam logic [2:0] src_amp_one = 3'h2;
	localparam logic [2:0] src_amp_two = 3'h3;
	localparam logic [2:0] src_neg_supply = 3'h4;
	localparam logic [3:0] ch_amp_one = 4'h1;
	localparam logic [3:0] ch_amp_two = 4'h2;
	localparam logic [3:0] ch_neg_supply = 4'h3;
	localparam logic [3:0] ch_last_ext = 4'ha;
	typedef enum logic [1:0] {mode_manual, mode_auto_one, mode_auto_two} conv_mode_t;
	typedef enum logic [2:0] {
		route_none, route_ext, route_bandgap, route_amp_one, route_amp_two, route_neg_supply
	} route_t;
endpackage

// ---- design/adc_clock_divider.sv ----
// Converter clock divider: power-of-two division of the system clock
`timescale 1ns/1ps
`default_nettype none
module adc_clock_divider
#(
	parameter int sel_width = 3
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [sel_width-1:0] div_select,
	output logic tick
);
	typedef struct packed
	{
		logic [(1<<sel_width)-2:0] count;
		logic tick;
	} div_state_t;

	div_state_t state;
	div_state_t next_state;
	logic [(1<<sel_width)-2:0] limit;

	// ----------------------------------------
	// Tick once every 2**n system clocks
	// ----------------------------------------
	always_comb
	begin
		limit = ((1<<sel_width)-1)'((1 << div_select) - 1);
		next_state = state;
		next_state.tick = 1'b0;
		if (!run)
		begin
			next_state.count = '0;
		end
		else if (state.count >= limit)
		begin
			next_state.count = '0;
			next_state.tick = 1'b1;
		end
		else
		begin
			next_state.count = state.count + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign tick = state.tick;
endmodule
`default_nettype wire

// ---- design/adc_input_mux_and_clock_control.sv ----
// Converter input routing, pin takeover, clock division and power control with APB access
//
// Function
// - Analog pin selection disables other pin functions
// - Analog pin selection disconnects pull-high resistor
// - Analog pin selection overrides port direction
// - Source select routes external or internal signals
// - Channel codes 0-10 pick pins, else float
// - Dual mode: per-channel source bit, internal/external
// - Dual mode internal code decode, default bandgap
// - Internal selection switches external path off
// - Converter clock is system clock over 2**n; here over 2**(n+1), two divider ticks per period
// - Enable bit powers converter on or off
// - Conversion: 4 sample plus 12 convert periods
// - Manual start by low-high-low start bit
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adc_input_mux_and_clock_control
#(
	parameter int num_ext = adc_ctl_pkg::num_ext
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic auto_trigger,
	output logic converter_power_enable,
	output logic conv_clock,
	output logic conv_sample,
	output logic conv_busy,
	output logic [num_ext-1:0] ext_switch_on,
	output logic bandgap_select,
	output logic amp_one_select,
	output logic amp_two_select,
	output logic neg_supply_select,
	output logic [num_ext-1:0] pin_analog_mode,
	output logic [num_ext-1:0] pin_digital_enable,
	output logic [num_ext-1:0] pin_pull_high_on,
	output logic [num_ext-1:0] pin_output_allowed
);
	typedef struct packed
	{
		logic [3:0] ext_channel_select;
		logic start;
		logic converter_power_enable;
		adc_ctl_pkg::conv_mode_t mode;
		logic [2:0] conv_clock_divider_select;
		logic [2:0] conv_source_select;
		logic dual_ch1_source_bit;
		logic [3:0] dual_ch1_signal_select;
		logic dual_ch2_source_bit;
		logic [3:0] dual_ch2_signal_select;
		logic [num_ext-1:0] pin_function_select;
		logic [num_ext-1:0] pin_pull_high;
		logic [num_ext-1:0] pin_direction_in;
		logic trig_sync1;
		logic trig_sync2;
		logic trig_last;
		logic busy;
		logic channel;
		logic [4:0] period_count;
		logic [2:0] active_div;
		adc_ctl_pkg::route_t route;
		logic [3:0] route_ext;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic conv_clock;
		logic conv_sample;
		logic [num_ext-1:0] ext_switch_on;
		logic bandgap_select, amp_one_select, amp_two_select, neg_supply_select;
		logic [num_ext-1:0] pin_analog_mode;
		logic [num_ext-1:0] pin_digital_enable;
		logic [num_ext-1:0] pin_pull_high_on;
		logic [num_ext-1:0] pin_output_allowed;
	} ctl_state_t;

	ctl_state_t s;
	ctl_state_t n;
	logic tick;
	logic setup;
	logic wr;
	logic mapped;
	logic [31:0] rd;
	logic trig_rise;
	adc_ctl_pkg::route_t pick_route;
	logic [3:0] pick_ext;

	adc_clock_divider #(.sel_width(3)) u_div
	(
		.pclk(pclk),
		.presetn(presetn),
		.run(s.busy),
		.div_select(s.active_div),
		.tick(tick)
	);

	// ----------------------------------------
	// Decode of the selection for the next conversion
	// ----------------------------------------
	function automatic adc_ctl_pkg::route_t ext_route(input logic [3:0] code);
		if (code <= adc_ctl_pkg::ch_last_ext)
		begin
			ext_route = adc_ctl_pkg::route_ext;
		end
		else
		begin
			ext_route = adc_ctl_pkg::route_none;
		end
	endfunction

	function automatic adc_ctl_pkg::route_t dual_route(input logic src, input logic [3:0] code);
		if (src)
		begin
			dual_route = ext_route(code);
		end
		else
		begin
			case (code)
				adc_ctl_pkg::ch_amp_one: dual_route = adc_ctl_pkg::route_amp_one;
				adc_ctl_pkg::ch_amp_two: dual_route = adc_ctl_pkg::route_amp_two;
				adc_ctl_pkg::ch_neg_supply: dual_route = adc_ctl_pkg::route_neg_supply;
				default: dual_route = adc_ctl_pkg::route_bandgap;
			endcase
		end
	endfunction

	always_comb
	begin
		pick_ext = s.ext_channel_select;
		if (s.mode == adc_ctl_pkg::mode_auto_two)
		begin
			if (s.channel)
			begin
				pick_route = dual_route(s.dual_ch2_source_bit, s.dual_ch2_signal_select);
				pick_ext = s.dual_ch2_signal_select;
			end
			else
			begin
				pick_route = dual_route(s.dual_ch1_source_bit, s.dual_ch1_signal_select);
				pick_ext = s.dual_ch1_signal_select;
			end
		end
		else
		begin
			case (s.conv_source_select)
				adc_ctl_pkg::src_bandgap: pick_route = adc_ctl_pkg::route_bandgap;
				adc_ctl_pkg::src_amp_one: pick_route = adc_ctl_pkg::route_amp_one;
				adc_ctl_pkg::src_amp_two: pick_route = adc_ctl_pkg::route_amp_two;
				adc_ctl_pkg::src_neg_supply: pick_route = adc_ctl_pkg::route_neg_supply;
				default: pick_route = ext_route(s.ext_channel_select);
			endcase
		end
	end

	// ----------------------------------------
	// Bus decode and read data
	// ----------------------------------------
	assign setup = psel && !penable;
	assign wr = psel && penable && s.pready && pwrite && mapped;
	assign trig_rise = s.trig_sync2 && !s.trig_last;

	always_comb
	begin
		mapped = 1'b1;
		rd = adc_ctl_pkg::reset_value;
		case (paddr)
			adc_ctl_pkg::off_conv_control_reg0:
			begin
				rd[adc_ctl_pkg::pos_ext_channel_select +: 4] = s.ext_channel_select;
				rd[adc_ctl_pkg::pos_start] = s.start;
				rd[adc_ctl_pkg::pos_converter_power_enable] = s.converter_power_enable;
				rd[adc_ctl_pkg::pos_mode +: 2] = s.mode;
			end
			adc_ctl_pkg::off_conv_control_reg1:
			begin
				rd[adc_ctl_pkg::pos_conv_clock_divider_select +: 3] = s.conv_clock_divider_select;
				rd[adc_ctl_pkg::pos_conv_source_select +: 3] = s.conv_source_select;
			end
			adc_ctl_pkg::off_dual_ch1_select_reg:
			begin
				rd[adc_ctl_pkg::pos_dual_chan_signal_select +: 4] = s.dual_ch1_signal_select;
				rd[adc_ctl_pkg::pos_dual_chan_source_bit] = s.dual_ch1_source_bit;
			end
			adc_ctl_pkg::off_dual_ch2_select_reg:
			begin
				rd[adc_ctl_pkg::pos_dual_chan_signal_select +: 4] = s.dual_ch2_signal_select;
				rd[adc_ctl_pkg::pos_dual_chan_source_bit] = s.dual_ch2_source_bit;
			end
			adc_ctl_pkg::off_pin_function_select: rd[num_ext-1:0] = s.pin_function_select;
			adc_ctl_pkg::off_pin_pull_high: rd[num_ext-1:0] = s.pin_pull_high;
			adc_ctl_pkg::off_pin_direction: rd[num_ext-1:0] = s.pin_direction_in;
			adc_ctl_pkg::off_status:
			begin
				rd[adc_ctl_pkg::pos_busy] = s.busy;
				rd[adc_ctl_pkg::pos_phase_sample] = s.conv_sample;
				rd[adc_ctl_pkg::pos_active_channel] = s.channel;
			end
			default: mapped = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		n = s;
		n.pready = setup;
		n.pslverr = setup && !mapped;
		n.prdata = (setup && !pwrite) ? rd : 32'h0000_0000;
		n.trig_sync1 = auto_trigger;
		n.trig_sync2 = s.trig_sync1;
		n.trig_last = s.trig_sync2;
		if (wr)
		begin
			case (paddr)
				adc_ctl_pkg::off_conv_control_reg0:
				begin
					n.ext_channel_select = pwdata[adc_ctl_pkg::pos_ext_channel_select +: 4];
					n.start = pwdata[adc_ctl_pkg::pos_start];
					n.converter_power_enable = pwdata[adc_ctl_pkg::pos_converter_power_enable];
					n.mode = adc_ctl_pkg::conv_mode_t'(pwdata[adc_ctl_pkg::pos_mode +: 2]);
				end
				adc_ctl_pkg::off_conv_control_reg1:
				begin
					n.conv_clock_divider_select = pwdata[adc_ctl_pkg::pos_conv_clock_divider_select +: 3];
					n.conv_source_select = pwdata[adc_ctl_pkg::pos_conv_source_select +: 3];
				end
				adc_ctl_pkg::off_dual_ch1_select_reg:
				begin
					n.dual_ch1_signal_select = pwdata[adc_ctl_pkg::pos_dual_chan_signal_select +: 4];
					n.dual_ch1_source_bit = pwdata[adc_ctl_pkg::pos_dual_chan_source_bit];
				end
				adc_ctl_pkg::off_dual_ch2_select_reg:
				begin
					n.dual_ch2_signal_select = pwdata[adc_ctl_pkg::pos_dual_chan_signal_select +: 4];
					n.dual_ch2_source_bit = pwdata[adc_ctl_pkg::pos_dual_chan_source_bit];
				end
				adc_ctl_pkg::off_pin_function_select: n.pin_function_select = pwdata[num_ext-1:0];
				adc_ctl_pkg::off_pin_pull_high: n.pin_pull_high = pwdata[num_ext-1:0];
				adc_ctl_pkg::off_pin_direction: n.pin_direction_in = pwdata[num_ext-1:0];
				default: n.start = s.start;
			endcase
		end
		// Conversion sequencer
		if (!n.converter_power_enable)
		begin
			n.busy = 1'b0;
			n.channel = 1'b0;
		end
		else if (!s.busy)
		begin
			if ((s.mode == adc_ctl_pkg::mode_manual && s.start && wr
				&& paddr == adc_ctl_pkg::off_conv_control_reg0
				&& !pwdata[adc_ctl_pkg::pos_start])
				|| (s.mode != adc_ctl_pkg::mode_manual && trig_rise))
			begin
				n.busy = 1'b1;
				n.period_count = '0;
				n.route = pick_route;
				n.route_ext = pick_ext;
				n.active_div = s.conv_clock_divider_select;
			end
		end
		else if (tick)
		begin
			if (s.period_count == 5'(2 * adc_ctl_pkg::total_periods - 1))
			begin
				n.busy = 1'b0;
				if (s.mode == adc_ctl_pkg::mode_auto_two)
				begin
					n.channel = !s.channel;
				end
			end
			n.period_count = s.period_count + 5'h01;
		end
		n.conv_clock = n.busy && n.period_count[0];
		n.conv_sample = n.busy
			&& n.period_count < 5'(2 * adc_ctl_pkg::sample_periods);
		// Analog switch drive; internal routes keep every external switch open
		n.bandgap_select = n.busy && n.route == adc_ctl_pkg::route_bandgap;
		n.amp_one_select = n.busy && n.route == adc_ctl_pkg::route_amp_one;
		n.amp_two_select = n.busy && n.route == adc_ctl_pkg::route_amp_two;
		n.neg_supply_select = n.busy && n.route == adc_ctl_pkg::route_neg_supply;
		for (int i = 0; i < num_ext; i++)
		begin
			n.ext_switch_on[i] = n.busy && n.route == adc_ctl_pkg::route_ext
				&& n.route_ext == 4'(i) && s.pin_function_select[i];
			n.pin_analog_mode[i] = s.pin_function_select[i];
			n.pin_digital_enable[i] = !s.pin_function_select[i];
			n.pin_pull_high_on[i] = s.pin_pull_high[i] && !s.pin_function_select[i];
			n.pin_output_allowed[i] = !s.pin_direction_in[i] && !s.pin_function_select[i];
		end
		if (s.busy)
		begin
			n.period_count = tick ? s.period_count + 5'h01 : s.period_count;
		end
		if (s.busy && tick && s.period_count == 5'(2 * adc_ctl_pkg::total_periods - 1))
		begin
			n.period_count = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
		end
		else
		begin
			s <= n;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign converter_power_enable = s.converter_power_enable;
	assign conv_clock = s.conv_clock;
	assign conv_sample = s.conv_sample;
	assign conv_busy = s.busy;
	assign ext_switch_on = s.ext_switch_on;
	assign bandgap_select = s.bandgap_select;
	assign amp_one_select = s.amp_one_select;
	assign amp_two_select = s.amp_two_select;
	assign neg_supply_select = s.neg_supply_select;
	assign pin_analog_mode = s.pin_analog_mode;
	assign pin_digital_enable = s.pin_digital_enable;
	assign pin_pull_high_on = s.pin_pull_high_on;
	assign pin_output_allowed = s.pin_output_allowed;
endmodule
`default_nettype wire

// ---- sim/adc_ctl_assertions.sv ----
// Checker: port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctl_assertions
#(
	parameter int num_ext = adc_ctl_pkg::num_ext
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic conv_busy,
	input wire logic conv_sample,
	input wire logic converter_power_enable,
	input wire logic [num_ext-1:0] ext_switch_on,
	input wire logic bandgap_select,
	input wire logic amp_one_select,
	input wire logic amp_two_select,
	input wire logic neg_supply_select,
	input wire logic [num_ext-1:0] pin_analog_mode,
	input wire logic [num_ext-1:0] pin_digital_enable,
	input wire logic [num_ext-1:0] pin_pull_high_on,
	input wire logic [num_ext-1:0] pin_output_allowed
);
	logic [3:0] int_sel;
	assign int_sel = {bandgap_select, amp_one_select, amp_two_select, neg_supply_select};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence busy_hold;
		conv_busy && $past(conv_busy);
	endsequence
	sequence sample_end;
		$fell(conv_sample);
	endsequence
	digital_off_a: assert property ((pin_digital_enable & pin_analog_mode) == '0)
		else $error("digital function on analog pin");
	pull_off_a: assert property ((pin_pull_high_on & pin_analog_mode) == '0)
		else $error("pull-high on analog pin");
	drive_off_a: assert property ((pin_output_allowed & pin_analog_mode) == '0)
		else $error("output allowed on analog pin");
	int_onehot_a: assert property ($onehot0(int_sel))
		else $error("several internal sources");
	ext_onehot_a: assert property ($onehot0(ext_switch_on))
		else $error("several external switches");
	ext_analog_a: assert property ((ext_switch_on & ~pin_analog_mode) == '0)
		else $error("switch on a digital pin");
	paths_apart_a: assert property ((int_sel != 4'h0) |-> ext_switch_on == '0)
		else $error("internal and external joined");
	route_hold_a: assert property (busy_hold |-> $stable(ext_switch_on) && $stable(int_sel))
		else $error("routing moved during conversion");
	power_busy_a: assert property (conv_busy |-> converter_power_enable)
		else $error("conversion while powered off");
	sample_first_a: assert property (sample_end |-> conv_busy)
		else $error("no conversion after sampling");
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Testbench: self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, auto_trigger;
	logic converter_power_enable, conv_clock, conv_sample, conv_busy, err, got;
	logic bandgap_select, amp_one_select, amp_two_select, neg_supply_select;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [10:0] ext_switch_on, pin_analog_mode, pin_digital_enable;
	logic [10:0] pin_pull_high_on, pin_output_allowed, snap_ext;
	logic [3:0] snap_int;
	int rises, srises, t1, t2;
	int error_cnt = 0;
	int checks = 0;
	adc_input_mux_and_clock_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .auto_trigger(auto_trigger),
		.converter_power_enable(converter_power_enable), .conv_clock(conv_clock),
		.conv_sample(conv_sample), .conv_busy(conv_busy), .ext_switch_on(ext_switch_on),
		.bandgap_select(bandgap_select), .amp_one_select(amp_one_select),
		.amp_two_select(amp_two_select), .neg_supply_select(neg_supply_select),
		.pin_analog_mode(pin_analog_mode), .pin_digital_enable(pin_digital_enable),
		.pin_pull_high_on(pin_pull_high_on), .pin_output_allowed(pin_output_allowed));
	// ----
	// Shared tasks
	// ----
	task conclude;
		$display("errors=%0d checks=%0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		got = pready;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (got !== 1'b1)
		begin
			error_cnt++;
			conclude;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task conv_run;
		int n;
		logic pc;
		n = 0;
		pc = 1'b0;
		rises = 0;
		srises = 0;
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (conv_busy !== 1'b1 && n < 64);
		while (conv_busy === 1'b1 && n < 8000)
		begin
			snap_ext = ext_switch_on;
			snap_int = {bandgap_select, amp_one_select, amp_two_select, neg_supply_select};
			if (conv_clock === 1'b1 && pc === 1'b0)
			begin
				rises++;
				srises += (conv_sample === 1'b1);
				t1 = (rises == 1) ? n : t1;
				t2 = (rises == 2) ? n : t2;
			end
			pc = conv_clock;
			@(negedge pclk);
			n++;
		end
		if (n >= 8000 || rises == 0)
		begin
			error_cnt++;
			conclude;
		end
		@(posedge pclk);
	endtask
	task convert(input logic [7:0] v);
		wr(8'h00, {24'h0, v});
		repeat (8) @(posedge pclk);
		wr(8'h00, {24'h0, v | 8'h10});
		@(negedge pclk);
		chk(32'(conv_busy), 32'h0);
		@(posedge pclk);
		wr(8'h00, {24'h0, v});
		conv_run;
	endtask
	task trig;
		auto_trigger <= 1'b1;
		conv_run;
		auto_trigger <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	// ----
	// Scenarios
	// ----
	task s_pins;
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		wr(8'h14, 32'h7ff);
		wr(8'h18, 32'h0f0);
		wr(8'h10, 32'h70c);
		@(negedge pclk);
		chk(32'(pin_analog_mode), 32'h70c);
		chk(32'(pin_digital_enable), 32'h0f3);
		chk(32'(pin_pull_high_on), 32'h0f3);
		chk(32'(pin_output_allowed), 32'h003);
		@(posedge pclk);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h70c);
		apb(1'b0, 8'h24, 32'h0);
		chk(32'(err), 32'h1);
	endtask
	task s_route;
		for (int s = 0; s < 8; s++)
		begin
			wr(8'h04, (32'(s) << 4) | 32'h4);
			convert(8'(s + 3) | 8'h20);
			chk(32'(snap_ext), 32'((s == 0 || s > 4) ? 11'h1 << (s + 3) : 11'h0));
			chk(32'(snap_int), (s > 0 && s < 5) ? 32'h10 >> s : 32'h0);
		end
		wr(8'h04, 32'h4);
		convert(8'h2b);
		chk(32'({snap_ext, snap_int}), 32'h0);
	endtask
	task s_power;
		@(negedge pclk);
		chk(32'(converter_power_enable), 32'h1);
		@(posedge pclk);
		wr(8'h00, 32'h13);
		wr(8'h00, 32'h03);
		repeat (4) @(negedge pclk);
		chk(32'(conv_busy), 32'h0);
		chk(32'(converter_power_enable), 32'h0);
		@(posedge pclk);
	endtask
	task s_div;
		for (int k = 0; k < 8; k++)
		begin
			wr(8'h04, 32'(k));
			convert(8'h23);
			chk(32'(t2 - t1), 32'(2 << k));
			chk(32'(rises), 32'h10);
			chk(32'(srises), 32'h4);
		end
	endtask
	task s_dual;
		wr(8'h04, 32'h24);
		wr(8'h00, 32'h62);
		trig;
		chk(32'(snap_int), 32'h4);
		wr(8'h0c, 32'h1a);
		wr(8'h00, 32'ha2);
		for (int c = 0; c < 5; c++)
		begin
			wr(8'h08, 32'(c));
			trig;
			chk(32'(snap_int), (c > 0 && c < 4) ? 32'h8 >> c : 32'h8);
			trig;
			chk(32'({snap_ext, snap_int}), 32'h4000);
		end
	endtask
	// ----
	// Clock and main sequence
	// ----
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		auto_trigger = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_pins;
		s_route;
		s_power;
		s_div;
		s_dual;
		wr(8'h00, 32'h0);
		conclude;
	end
endmodule
bind adc_input_mux_and_clock_control adc_ctl_assertions #(.num_ext(num_ext)) u_chk (
	.pclk(pclk), .presetn(presetn), .conv_busy(conv_busy), .conv_sample(conv_sample),
	.converter_power_enable(converter_power_enable), .ext_switch_on(ext_switch_on),
	.bandgap_select(bandgap_select), .amp_one_select(amp_one_select),
	.amp_two_select(amp_two_select), .neg_supply_select(neg_supply_select),
	.pin_analog_mode(pin_analog_mode), .pin_digital_enable(pin_digital_enable),
	.pin_pull_high_on(pin_pull_high_on), .pin_output_allowed(pin_output_allowed));
`default_nettype wire
